//--- shared/ers_pkg.sv
// Purpose: Constants and carrier types for the Ethernet receive error statistics block
// Assumes: One 40 MHz core clock, synchronous active-high port reset
// Notes: Counter slots are indexed by the IDX_ constants below
//
// Contract
// - Count short frames with bad check sequence
// - Count short frames with good check sequence
// - Count long frames; option adds bad ones on 10/100
// - Separate count of long bad frames
// - Check errors only for valid-size frames
// - Count every tagged frame received
// - Count invalid line-code symbols
// - Count pause frames only when flow control on
// - Odd bit length, bad check: alignment count
// - Odd bit length, good check: dribble count
// - Count non-late collisions, once per frame
// - Collision past byte 56 counts as late
// - Count frames resent after collisions
// - Count frames meeting sixteen consecutive collisions
// - Gigabit: count frames holding symbol errors
// - Gigabit: count misaligned comma detections
package ers_pkg;
  // ==========================================================
  // Frame length limits, in bytes
  localparam int MIN_LEN = 64; // Shorter than this is runt class
  localparam int MAX_LEN = 1518; // Longer than this is oversize class
  localparam int LEN_W = 14; // Width of the frame length field
  localparam int LATE_BYTE = 56; // Byte position where collisions turn late
  localparam int COL_LIMIT = 16; // Consecutive collisions that abandon a frame
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 40000; // Core clock rate
  localparam int RATE_WIN_MS = 1000; // Rate window, one second
  localparam int RATE_CYCLES = CLK_KHZ * RATE_WIN_MS; // Cycles per rate window
  localparam int CNT_W = 32; // Default counter width
  // ==========================================================
  // Counter slots
  localparam int IDX_FRAG = 0; // Short, bad check
  localparam int IDX_UNDER = 1; // Short, good check
  localparam int IDX_OVER = 2; // Long frames
  localparam int IDX_CRC = 3; // Valid size, bad check
  localparam int IDX_TAG = 4; // Tagged frames
  localparam int IDX_LINE = 5; // Line-code symbol errors
  localparam int IDX_PAUSE = 6; // Pause frames
  localparam int IDX_ALIGN = 7; // Odd bits, bad check
  localparam int IDX_DRIB = 8; // Odd bits, good check
  localparam int IDX_COL = 9; // Normal collisions
  localparam int IDX_LATE = 10; // Late collisions
  localparam int IDX_RETX = 11; // Frames resent after collisions
  localparam int IDX_ABAND = 12; // Frames abandoned
  localparam int IDX_LBAD = 13; // Long, bad check
  localparam int IDX_CEFR = 14; // Frames with symbol errors
  localparam int IDX_COMMA = 15; // Misaligned commas
  localparam int N_CTR = 16; // Number of counter slots
  // ==========================================================
  // Summary of a received frame, valid with the frame-done strobe
  typedef struct packed {
    logic [LEN_W-1:0] len; // Length in whole bytes
    logic fcs_ok; // Check sequence matched after truncation
    logic odd_bits; // Bit length not a multiple of eight
    logic vlan; // Frame carried a VLAN tag
    logic pause; // Frame was a PAUSE frame
  } ers_rx_info_type;
endpackage : ers_pkg

//--- design/ers_counter.sv
// Purpose: One statistics counter with a per-window rate companion
// Assumes: Increment and tick are same-clock pulses
// Notes: Counter wraps silently at full scale
`timescale 1ns/100ps
module ers_counter #(
  parameter int W = ers_pkg::CNT_W // Counter width
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_ce, // Clock enable, freezes state when low
  input wire logic i_inc, // Count one event
  input wire logic i_tick, // Rate window boundary
  output logic [W-1:0] o_count, // Running total
  output logic [W-1:0] o_rate // Increments in last window
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] cnt; // Running total
    logic [W-1:0] acc; // Increments in the open window
    logic [W-1:0] rate; // Increments in the last closed window
  } ers_ctr_state_type;
  ers_ctr_state_type st_ff;
  ers_ctr_state_type nxt_st;

  // Next state: an increment in the tick cycle belongs to the closing window
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cnt = st_ff.cnt + W'(i_inc);
    if (i_tick) begin
      nxt_st.rate = st_ff.acc + W'(i_inc);
      nxt_st.acc = '0;
    end else begin
      nxt_st.acc = st_ff.acc + W'(i_inc);
    end
  end

  // Register, reset clears every total
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_count = st_ff.cnt;
  assign o_rate = st_ff.rate;

  // ==========================================================
  // Checks
  rate_latch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_tick |=> o_rate == $past(st_ff.acc) + W'($past(i_inc)))
    else $error("rate value not latched from window");
  reset_clear_a: assert property (@(posedge i_core_clk)
    i_rst |=> o_count == '0 && o_rate == '0)
    else $error("counter not cleared by reset");
endmodule : ers_counter

//--- design/ers_stats.sv
// Purpose: Receive error and collision statistics for one Ethernet port
// Assumes: Frame strobes come from receive logic on the core clock;
//   collision detect is a raw pin from the physical layer
// Notes: All counters clear on port reset and hold while i_ce is low
`timescale 1ns/100ps
module ers_stats #(
  parameter int CW = ers_pkg::CNT_W, // Counter width
  parameter int RATE_CYC = ers_pkg::RATE_CYCLES // Cycles per rate window
) (
  input wire logic i_core_clk, // Core clock, 40 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_ce, // Clock enable
  input wire logic i_gig_mode, // Port runs at gigabit rate
  input wire logic i_fc_enable, // Flow control enabled
  input wire logic i_over_any_fcs, // 10/100: oversize counts bad frames too
  input wire logic i_rx_active, // Frame in progress on the line
  input wire logic i_rx_byte, // One byte received, pulse
  input wire logic i_rx_done, // Frame ended, pulse
  input wire ers_pkg::ers_rx_info_type i_rx_info, // Frame summary at done
  input wire logic i_sym_err, // Invalid line-code symbol, pulse
  input wire logic i_comma_misalign, // Comma seen out of alignment, pulse
  input wire logic i_col_pin, // Collision detect pin, asynchronous
  input wire logic i_tx_try_end, // Transmit attempt finished, pulse
  input wire logic i_tx_try_col, // That attempt met a collision
  output logic [ers_pkg::N_CTR-1:0][CW-1:0] o_count, // Counter totals
  output logic [ers_pkg::N_CTR-1:0][CW-1:0] o_rate, // Counts in last window
  output logic o_rate_tick // Rate values refresh one cycle later, pulse
);
  // ==========================================================
  // Local widths
  localparam int BC_W = 6; // Byte position width, saturates above late point
  localparam int TW = 5; // Consecutive collision count width
  localparam int SW = 32; // Window timer width
  localparam int LEN_W = ers_pkg::LEN_W; // Frame length width

  // All state of this module
  typedef struct packed {
    logic col_s1; // Collision pin, first stage
    logic col_s2; // Second stage
    logic col_s3; // Third stage
    logic col_lvl; // Filtered collision level
    logic [BC_W-1:0] byte_cnt; // Bytes seen in the current frame
    logic col_seen; // A collision already counted for this frame
    logic sym_seen; // A symbol error seen in this frame
    logic [TW-1:0] tx_consec; // Consecutive collided attempts
    logic tx_had_col; // Current transmit frame has collided
    logic [SW-1:0] sec_cnt; // Rate window timer
    logic tick; // Window boundary pulse
  } ers_state_type;

  ers_state_type st_ff;
  ers_state_type nxt_st;
  logic [ers_pkg::N_CTR-1:0] inc; // One increment per counter slot

  // Frame length classes and collision edge terms
  logic is_short; // Below minimum length
  logic is_long; // Above maximum length
  logic is_valid; // Inside the valid size range
  logic col_rise; // Filtered collision level rising
  logic col_late; // Rising edge falls past the late point

  // ==========================================================
  // Length classification
  always_comb begin
    is_short = i_rx_info.len < LEN_W'(ers_pkg::MIN_LEN);
    is_long = i_rx_info.len > LEN_W'(ers_pkg::MAX_LEN);
    is_valid = !is_short && !is_long;
  end

  // Collision edge, seen on the filtered level only
  always_comb begin
    col_rise = st_ff.col_s2 && st_ff.col_s3 && !st_ff.col_lvl;
    col_late = st_ff.byte_cnt >= BC_W'(ers_pkg::LATE_BYTE);
  end

  // ==========================================================
  // Counter increments
  always_comb begin
    inc = '0;
    if (i_rx_done) begin
      // Bad check frames fall into exactly one length class
      inc[ers_pkg::IDX_FRAG] = is_short && !i_rx_info.fcs_ok;
      inc[ers_pkg::IDX_UNDER] = is_short && i_rx_info.fcs_ok;
      inc[ers_pkg::IDX_CRC] = is_valid && !i_rx_info.fcs_ok;
      inc[ers_pkg::IDX_LBAD] = is_long && !i_rx_info.fcs_ok;
      // Oversize takes bad frames only in the 10/100 variant
      inc[ers_pkg::IDX_OVER] = is_long && (i_rx_info.fcs_ok ||
        (i_over_any_fcs && !i_gig_mode));
      inc[ers_pkg::IDX_TAG] = i_rx_info.vlan;
      inc[ers_pkg::IDX_PAUSE] = i_rx_info.pause && i_fc_enable;
      // The check is judged on the truncated frame upstream
      inc[ers_pkg::IDX_ALIGN] = i_rx_info.odd_bits && !i_rx_info.fcs_ok;
      inc[ers_pkg::IDX_DRIB] = i_rx_info.odd_bits && i_rx_info.fcs_ok;
      // A symbol error in the last cycle still marks the frame
      inc[ers_pkg::IDX_CEFR] = i_gig_mode && (st_ff.sym_seen || i_sym_err);
    end
    inc[ers_pkg::IDX_LINE] = i_sym_err;
    inc[ers_pkg::IDX_COMMA] = i_comma_misalign && i_gig_mode;
    // Only the first collision of a frame counts, sorted by position
    if (col_rise && !st_ff.col_seen) begin
      inc[ers_pkg::IDX_COL] = !col_late;
      inc[ers_pkg::IDX_LATE] = col_late;
    end
    if (i_tx_try_end) begin
      // A clean attempt after collisions means the frame was resent
      inc[ers_pkg::IDX_RETX] = !i_tx_try_col && st_ff.tx_had_col;
      inc[ers_pkg::IDX_ABAND] = i_tx_try_col &&
        (st_ff.tx_consec == TW'(ers_pkg::COL_LIMIT - 1));
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Three-stage pin synchroniser; first stage feeds the second only
    // Pulses shorter than two agreeing samples are dropped as line noise
    nxt_st.col_s1 = i_col_pin;
    nxt_st.col_s2 = st_ff.col_s1;
    nxt_st.col_s3 = st_ff.col_s2;
    // Level moves only once the second and third stages agree
    if (st_ff.col_s2 == st_ff.col_s3) begin
      nxt_st.col_lvl = st_ff.col_s3;
    end
    // Byte position, saturating so long frames stay late
    if (!i_rx_active) begin
      nxt_st.byte_cnt = '0;
    end else if (i_rx_byte && (st_ff.byte_cnt != '1)) begin
      nxt_st.byte_cnt = st_ff.byte_cnt + 1'b1;
    end
    // Once-per-frame collision flag; outside frames each edge counts
    if (!i_rx_active) begin
      nxt_st.col_seen = 1'b0;
    end
    if (col_rise && i_rx_active) begin
      nxt_st.col_seen = 1'b1;
    end
    // Symbol error flag; an error in the done cycle is counted directly by that frame
    if (i_rx_done) begin
      nxt_st.sym_seen = 1'b0;
    end else if (i_sym_err && i_rx_active) begin
      nxt_st.sym_seen = 1'b1;
    end
    // Transmit collision history
    if (i_tx_try_end) begin
      if (!i_tx_try_col) begin
        nxt_st.tx_consec = '0;
        nxt_st.tx_had_col = 1'b0;
      end else if (inc[ers_pkg::IDX_ABAND]) begin
        // Frame is given up; the next attempt is a new frame
        nxt_st.tx_consec = '0;
        nxt_st.tx_had_col = 1'b0;
      end else begin
        nxt_st.tx_consec = st_ff.tx_consec + 1'b1;
        nxt_st.tx_had_col = 1'b1;
      end
    end
    // Rate window timer
    if (st_ff.sec_cnt == SW'(RATE_CYC - 1)) begin
      nxt_st.sec_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.sec_cnt = st_ff.sec_cnt + 1'b1;
      nxt_st.tick = 1'b0;
    end
  end

  // ==========================================================
  // State register, frozen while the clock enable is low
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_rate_tick = st_ff.tick;

  // ==========================================================
  // Counter bank; the tick is registered so every slot closes together
  for (genvar g = 0; g < ers_pkg::N_CTR; g++) begin : g_ctr
    ers_counter #(
      .W(CW)
    ) u_ctr (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_inc(inc[g]),
      .i_tick(st_ff.tick),
      .o_count(o_count[g]),
      .o_rate(o_rate[g])
    );
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  frag_count_a: assert property (
    i_ce && i_rx_done && is_short && !i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_FRAG] == $past(o_count[ers_pkg::IDX_FRAG]) + 1'b1)
    else $error("fragment not counted");
  under_count_a: assert property (
    i_ce && i_rx_done && is_short && i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_UNDER] == $past(o_count[ers_pkg::IDX_UNDER]) + 1'b1)
    else $error("undersize not counted");
  over_good_a: assert property (
    i_ce && i_rx_done && is_long && i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_OVER] == $past(o_count[ers_pkg::IDX_OVER]) + 1'b1)
    else $error("oversize not counted");
  over_gig_bad_a: assert property (
    i_ce && i_rx_done && i_gig_mode && !i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_OVER] == $past(o_count[ers_pkg::IDX_OVER]))
    else $error("bad frame counted as oversize");
  one_class_a: assert property (
    i_rx_done && !i_rx_info.fcs_ok |->
    $onehot({inc[ers_pkg::IDX_FRAG], inc[ers_pkg::IDX_CRC], inc[ers_pkg::IDX_LBAD]}))
    else $error("bad frame not in exactly one class");
  crc_count_a: assert property (
    i_ce && i_rx_done && is_valid && !i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_CRC] == $past(o_count[ers_pkg::IDX_CRC]) + 1'b1)
    else $error("check error not counted");
  long_bad_a: assert property (
    i_ce && i_rx_done && is_long && !i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_LBAD] == $past(o_count[ers_pkg::IDX_LBAD]) + 1'b1)
    else $error("long bad frame not counted");
  tag_count_a: assert property (
    i_ce && i_rx_done && i_rx_info.vlan |=>
    o_count[ers_pkg::IDX_TAG] == $past(o_count[ers_pkg::IDX_TAG]) + 1'b1)
    else $error("tagged frame not counted");
  line_count_a: assert property (
    i_ce && i_sym_err |=>
    o_count[ers_pkg::IDX_LINE] == $past(o_count[ers_pkg::IDX_LINE]) + 1'b1)
    else $error("symbol error not counted");
  pause_gate_a: assert property (
    i_ce && !i_fc_enable |=>
    o_count[ers_pkg::IDX_PAUSE] == $past(o_count[ers_pkg::IDX_PAUSE]))
    else $error("pause counted with flow control off");
  align_drib_a: assert property (
    i_ce && i_rx_done && i_rx_info.odd_bits |=>
    o_count[ers_pkg::IDX_ALIGN] - $past(o_count[ers_pkg::IDX_ALIGN]) ==
    CW'(!$past(i_rx_info.fcs_ok)))
    else $error("alignment count wrong");
  dribble_a: assert property (
    i_ce && i_rx_done && i_rx_info.odd_bits && i_rx_info.fcs_ok |=>
    o_count[ers_pkg::IDX_DRIB] == $past(o_count[ers_pkg::IDX_DRIB]) + 1'b1)
    else $error("dribble not counted");
  col_once_a: assert property (
    i_ce && col_rise && st_ff.col_seen |=>
    o_count[ers_pkg::IDX_COL] == $past(o_count[ers_pkg::IDX_COL]))
    else $error("second collision counted in one frame");
  late_col_a: assert property (
    i_ce && col_rise && !st_ff.col_seen && st_ff.byte_cnt >= BC_W'(ers_pkg::LATE_BYTE)
    |=> o_count[ers_pkg::IDX_LATE] == $past(o_count[ers_pkg::IDX_LATE]) + 1'b1)
    else $error("late collision not counted");
  abandon_a: assert property (
    i_ce && i_tx_try_end && i_tx_try_col && st_ff.tx_consec == TW'(ers_pkg::COL_LIMIT - 1)
    |=> o_count[ers_pkg::IDX_ABAND] == $past(o_count[ers_pkg::IDX_ABAND]) + 1'b1)
    else $error("abandoned frame not counted");
  code_frame_a: assert property (
    i_ce && !i_gig_mode |=>
    o_count[ers_pkg::IDX_CEFR] == $past(o_count[ers_pkg::IDX_CEFR]) &&
    o_count[ers_pkg::IDX_COMMA] == $past(o_count[ers_pkg::IDX_COMMA]))
    else $error("gigabit counter moved outside gigabit");
  tick_space_a: assert property (
    o_rate_tick |=> !o_rate_tick)
    else $error("rate tick longer than one cycle");

  // Main scenarios that the bench is expected to reach
  cov_frag_c: cover property (i_ce && inc[ers_pkg::IDX_FRAG]);
  cov_cefr_c: cover property (i_ce && inc[ers_pkg::IDX_CEFR]);
  cov_late_c: cover property (i_ce && inc[ers_pkg::IDX_LATE]);
  cov_aband_c: cover property (i_ce && inc[ers_pkg::IDX_ABAND]);
  cov_retx_c: cover property (i_ce && inc[ers_pkg::IDX_RETX]);
endmodule : ers_stats

//--- tb/ers_phy_model.sv
// Purpose: Physical layer stand-in driving receive, symbol and collision lines
// Assumes: Every line changes 1 ns after a rising clock edge
// Notes: Frame summary lines carry the inverse of the last frame when idle
`timescale 1ns/100ps
module ers_phy_model (
  input wire logic i_core_clk, // Core clock
  output logic o_rx_active, // Frame on the line
  output logic o_rx_byte, // Byte strobe
  output logic o_rx_done, // Frame end strobe
  output ers_pkg::ers_rx_info_type o_rx_info, // Frame summary
  output logic o_sym_err, // Bad symbol strobe
  output logic o_comma_misalign, // Comma slip strobe
  output logic o_col_pin, // Collision detect level
  output logic o_tx_try_end, // Transmit attempt end
  output logic o_tx_try_col // Attempt collided
);
  // ==========================================================
  // Idle state at time zero
  initial begin
    {o_rx_active, o_rx_byte, o_rx_done, o_sym_err} = 4'h0;
    {o_comma_misalign, o_col_pin, o_tx_try_end, o_tx_try_col} = 4'h0;
    o_rx_info = '0;
  end
  // ==========================================================
  // Helpers: n edges, then settle off the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  // Long pulse so the three-stage filter surely sees it
  task automatic col_pulse();
    o_col_pin = 1'b1;
    step(6);
    o_col_pin = 1'b0;
    step(6);
  endtask : col_pulse
  // One high cycle per bad symbol
  task automatic sym(input int n);
    o_sym_err = 1'b1;
    step(n);
    o_sym_err = 1'b0;
    step(1);
  endtask : sym
  // One high cycle per misaligned comma
  task automatic comma(input int n);
    o_comma_misalign = 1'b1;
    step(n);
    o_comma_misalign = 1'b0;
    step(1);
  endtask : comma
  // ==========================================================
  // Receive one frame; bytes pause while the collision pin is high
  task automatic rx_frame(input ers_pkg::ers_rx_info_type info, input int nbytes,
                          input int col_at, input bit twice, input int nsym);
    o_rx_active = 1'b1;
    if (nsym > 0) begin
      sym(nsym);
    end
    if (col_at > 0) begin
      o_rx_byte = 1'b1;
      step(col_at);
      o_rx_byte = 1'b0;
      col_pulse();
      if (twice) begin
        col_pulse();
      end
    end
    if (nbytes > 0) begin
      o_rx_byte = 1'b1;
      step(nbytes);
      o_rx_byte = 1'b0;
    end
    o_rx_done = 1'b1;
    o_rx_info = info;
    step(1);
    o_rx_done = 1'b0;
    o_rx_active = 1'b0;
    o_rx_info = ~info;
    step(1);
  endtask : rx_frame
  // ==========================================================
  // One transmit attempt; the collided line is junk between attempts
  task automatic tx_try(input bit col);
    o_tx_try_col = col;
    o_tx_try_end = 1'b1;
    step(1);
    o_tx_try_end = 1'b0;
    o_tx_try_col = ~col;
    step(1);
  endtask : tx_try
endmodule : ers_phy_model

//--- tb/test_ers_stats.sv
// Purpose: Self-checking bench for the receive error statistics block
// Assumes: Short rate window parameter keeps the run brief
// Notes: The frame, line, collision and transmit scenarios compare all sixteen counters against a snapshot
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp); \
  end \
end
module test_ers_stats;
  localparam int CW = 32; // Counter width
  localparam int RC = 50; // Rate window, shortened
  localparam int N = ers_pkg::N_CTR; // Counter slots
  // ==========================================================
  // Bench signals
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Port reset
  logic ce = 1'b1; // Clock enable
  logic gig = 1'b1; // Gigabit mode
  logic fc = 1'b1; // Flow control
  logic over_any = 1'b1; // Oversize counts bad frames on 10/100
  logic rx_active, rx_byte, rx_done, sym_err, comma, col_pin, try_end, try_col;
  ers_pkg::ers_rx_info_type rx_info; // Frame summary
  logic [N-1:0][CW-1:0] count, rate, snap; // Totals, rates, snapshot
  logic tick; // Rate refresh pulse
  int d[N]; // Expected increments since snapshot
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  // ==========================================================
  // Clock and partner
  always #12.5 clk = ~clk;
  ers_phy_model i_phy (.i_core_clk(clk), .o_rx_active(rx_active), .o_rx_byte(rx_byte),
    .o_rx_done(rx_done), .o_rx_info(rx_info), .o_sym_err(sym_err),
    .o_comma_misalign(comma), .o_col_pin(col_pin), .o_tx_try_end(try_end),
    .o_tx_try_col(try_col));
  ers_stats #(.CW(CW), .RATE_CYC(RC)) i_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_gig_mode(gig), .i_fc_enable(fc), .i_over_any_fcs(over_any),
    .i_rx_active(rx_active), .i_rx_byte(rx_byte), .i_rx_done(rx_done),
    .i_rx_info(rx_info), .i_sym_err(sym_err), .i_comma_misalign(comma),
    .i_col_pin(col_pin), .i_tx_try_end(try_end), .i_tx_try_col(try_col),
    .o_count(count), .o_rate(rate), .o_rate_tick(tick));
  // ==========================================================
  // Verdict; single exit point of the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] %0t run hung", $time);
      stop_test();
    end
  end
  // ==========================================================
  // Snapshot and whole-bank comparison
  task automatic snap_take();
    snap = count;
    foreach (d[i]) d[i] = 0;
  endtask : snap_take
  task automatic check_d(input string msg);
    for (int i = 0; i < N; i++) `CHK(count[i], snap[i] + CW'(d[i]), msg)
  endtask : check_d
  // One frame; mask bits mark slots expected to step by one
  task automatic fcase(input int len, input bit ok, odd, vl, pa, input logic [N-1:0] m);
    ers_pkg::ers_rx_info_type f;
    f = '{len: len[13:0], fcs_ok: ok, odd_bits: odd, vlan: vl, pause: pa};
    snap_take();
    foreach (d[i]) d[i] = int'(m[i]);
    i_phy.rx_frame(f, 0, -1, 1'b0, 0);
    check_d("frame class");
  endtask : fcase
  // ==========================================================
  // Scenarios
  task automatic t_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    `CHK(tick, 1'b0, "tick in reset")
    for (int i = 0; i < N; i++) begin
      `CHK(count[i], '0, "count after reset")
      `CHK(rate[i], '0, "rate after reset")
    end
    rst = 1'b0;
    $display("test reset done");
  endtask : t_reset
  // Size and error classes, mode switches, enable held low
  task automatic t_frames();
    fcase(63, 0, 0, 0, 0, 16'h0001);
    fcase(63, 1, 0, 0, 0, 16'h0002);
    fcase(64, 0, 0, 0, 0, 16'h0008);
    fcase(1518, 0, 0, 0, 0, 16'h0008);
    fcase(64, 1, 0, 0, 0, 16'h0000);
    fcase(1519, 1, 0, 0, 0, 16'h0004);
    fcase(1519, 0, 0, 0, 0, 16'h2000);
    fcase(100, 1, 0, 1, 0, 16'h0010);
    fcase(100, 1, 0, 0, 1, 16'h0040);
    fcase(100, 0, 1, 0, 0, 16'h0088);
    fcase(100, 1, 1, 0, 0, 16'h0100);
    fc = 1'b0;
    fcase(100, 1, 0, 0, 1, 16'h0000);
    gig = 1'b0;
    fcase(1519, 0, 0, 0, 0, 16'h2004);
    over_any = 1'b0;
    fcase(1519, 0, 0, 0, 0, 16'h2000);
    ce = 1'b0;
    fcase(63, 0, 0, 0, 0, 16'h0000);
    {ce, fc, over_any} = 3'h7;
    $display("test frames done");
  endtask : t_frames
  // Symbols and commas in both modes, symbol-bearing frame
  task automatic t_line();
    ers_pkg::ers_rx_info_type f;
    f = '{len: 14'h0064, fcs_ok: 1'b1, odd_bits: 1'b0, vlan: 1'b0, pause: 1'b0};
    snap_take();
    i_phy.sym(3);
    i_phy.comma(2);
    i_phy.rx_frame(f, 4, -1, 1'b0, 2);
    d[ers_pkg::IDX_LINE] = 5;
    check_d("slow line codes");
    gig = 1'b1;
    snap_take();
    i_phy.sym(1);
    i_phy.comma(2);
    i_phy.rx_frame(f, 4, -1, 1'b0, 2);
    d[ers_pkg::IDX_LINE] = 3;
    d[ers_pkg::IDX_COMMA] = 2;
    d[ers_pkg::IDX_CEFR] = 1;
    check_d("gigabit line codes");
    $display("test line done");
  endtask : t_line
  // Boundary of the late point, repeat in frame, idle collisions
  task automatic t_collide();
    ers_pkg::ers_rx_info_type f;
    f = '{len: 14'h0064, fcs_ok: 1'b1, odd_bits: 1'b0, vlan: 1'b0, pause: 1'b0};
    snap_take();
    i_phy.rx_frame(f, 10, 55, 1'b1, 0);
    d[ers_pkg::IDX_COL] = 1;
    check_d("early collision");
    snap_take();
    i_phy.rx_frame(f, 10, 56, 1'b0, 0);
    d[ers_pkg::IDX_LATE] = 1;
    check_d("late collision");
    snap_take();
    i_phy.col_pulse();
    i_phy.col_pulse();
    d[ers_pkg::IDX_COL] = 2;
    check_d("idle collisions");
    $display("test collide done");
  endtask : t_collide
  // Retry history: resend, abandon at sixteen, fifteen then clean
  task automatic t_tx();
    snap_take();
    repeat (3) i_phy.tx_try(1'b1);
    i_phy.tx_try(1'b0);
    i_phy.tx_try(1'b0);
    d[ers_pkg::IDX_RETX] = 1;
    check_d("resent frame");
    repeat (16) i_phy.tx_try(1'b1);
    d[ers_pkg::IDX_ABAND] = 1;
    check_d("abandoned frame");
    repeat (15) i_phy.tx_try(1'b1);
    i_phy.tx_try(1'b0);
    d[ers_pkg::IDX_RETX] = 2;
    check_d("fifteen then clean");
    $display("test tx done");
  endtask : t_tx
  // Wait for the rate pulse, bounded
  task automatic wait_tick(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_tick
  // Window length and per-window increments
  task automatic t_rate();
    int n;
    wait_tick(n);
    @(posedge clk);
    #1;
    i_phy.sym(3);
    wait_tick(n);
    `CHK(n, RC - 5, "window length")
    @(posedge clk);
    #1;
    `CHK(rate[ers_pkg::IDX_LINE], CW'(3), "line rate")
    `CHK(rate[ers_pkg::IDX_FRAG], CW'(0), "fragment rate")
    $display("test rate done");
  endtask : t_rate
  // ==========================================================
  // Main sequence
  initial begin
    t_reset(4);
    t_frames();
    t_line();
    t_collide();
    t_tx();
    t_rate();
    t_reset(2);
    stop_test();
  end
endmodule : test_ers_stats
